// ---- design/scar_cfg.svh ----
/*
  Bit positions, reset values, masks and transfer codes for the system
  control register bank. Assumes it is included by bare name wherever needed.
*/
`ifndef SCAR_CFG_SVH
`define SCAR_CFG_SVH

// Coprocessor transfer decode
`define SCAR_CP_SYS 4'hF
`define SCAR_CP_TEN 4'hA
`define SCAR_CP_ELEVEN 4'hB
`define SCAR_OPC1_CTL 3'h0
`define SCAR_CRN_CTL 4'h1
`define SCAR_CRM_CTL 4'h0
`define SCAR_OPC2_MAIN 3'h0
`define SCAR_OPC2_AUX 3'h1
`define SCAR_OPC2_CPA 3'h2

// Main system control register
`define SCAR_MAIN_RESET 32'h00C5_0078
`define SCAR_MAIN_RO_MASK 32'h01FF_83F8
`define SCAR_MAIN_SEC_ONLY_MASK 32'h0000_4000

// Auxiliary control register fields
`define SCAR_AUX_RESET 32'h0000_0000
`define SCAR_AUX_PARITY 9
`define SCAR_AUX_ONE_WAY 8
`define SCAR_AUX_DISJOINT 7
`define SCAR_AUX_COHERENT 6
`define SCAR_AUX_ZERO_LINE 3
`define SCAR_AUX_DSIDE_PF 2
`define SCAR_AUX_OUTER_PF 1
`define SCAR_AUX_MAINT_BC 0
`define SCAR_AUX_BASE_WMASK 32'h0000_01CE

// Coprocessor access control register fields
`define SCAR_CPA_RESET 32'h0000_0000
`define SCAR_CPA_TEN_LSB 20
`define SCAR_CPA_ELEVEN_LSB 22
`define SCAR_PERM_DENIED 2'h0
`define SCAR_PERM_PRIV 2'h1
`define SCAR_PERM_FULL 2'h3

`endif

// ---- design/scar_decode.sv ----
/*
  Decodes a coprocessor register transfer into one of the three registers.
  Assumes the transfer fields are stable while the request is offered.
*/
`timescale 1ns/100ps
`include "scar_cfg.svh"
module scar_decode (
  input wire logic [3:0] cp_num,
  input wire logic [2:0] opc1,
  input wire logic [3:0] crn,
  input wire logic [3:0] crm,
  input wire logic [2:0] opc2,
  output scar_pkg::scar_sel_t sel
);
  import scar_pkg::*;

  always_comb begin
    sel = SCAR_SEL_NONE;
    if (cp_num == `SCAR_CP_SYS && opc1 == `SCAR_OPC1_CTL &&
        crn == `SCAR_CRN_CTL && crm == `SCAR_CRM_CTL) begin
      case (opc2)
        `SCAR_OPC2_MAIN: sel = SCAR_SEL_MAIN; // [R6]
        `SCAR_OPC2_AUX: sel = SCAR_SEL_AUX; // [R7]
        `SCAR_OPC2_CPA: sel = SCAR_SEL_CPA;
        default: sel = SCAR_SEL_NONE;
      endcase
    end
  end
endmodule

// ---- design/scar_field_reg.sv ----
/*
  One 32-bit register whose bits are written only where the mask is set.
  Assumes the caller forms mask and enable for the access in hand.
*/
`timescale 1ns/100ps
module scar_field_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_mask,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= (q & ~wr_mask) | (wr_data & wr_mask);
    end
  end
endmodule

// ---- design/scar_pkg.sv ----
/*
  Types shared by the system control register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scar_pkg;
  typedef enum logic [1:0] {
    SCAR_S_IDLE = 2'b01,
    SCAR_S_RESP = 2'b10
  } scar_state_t;

  typedef enum logic [1:0] {
    SCAR_SEL_NONE = 2'h0,
    SCAR_SEL_MAIN = 2'h1,
    SCAR_SEL_AUX = 2'h2,
    SCAR_SEL_CPA = 2'h3
  } scar_sel_t;
endpackage

// ---- design/scar_regs.sv ----
/*
  System control register bank: main control (banked), auxiliary control and
  coprocessor access control, with mode and security gating of transfers.
  Assumes the pipeline offers one transfer at a time, synchronous to clk.
*/
// What this block does
// R1: User-mode reads or writes of main control raise Undefined Instruction.
// R2: With lock input high, Secure writes to main or auxiliary are undefined.
// R3: Non-secure writes to Secure-only main bits are silently ignored.
// R4: Reads of Secure-only main bits return the Secure copy.
// R5: Writes to read-only main bits are ignored.
// R6: Opcode1 0, c1, c0, opcode2 0 selects the main control register.
// R7: Opcode1 0, c1, c0, opcode2 1 selects the auxiliary register.
// R8: Auxiliary register is privileged-only, single copy, fully writable in Secure.
// R9: Non-secure: read-only unless permission set, then coherency bit only.
// R10: Coherency bit clear makes Inner Cacheable Shareable memory non-cacheable.
// R11: Multi-core with coherency: maintenance broadcast send and accept need bit 0.
// R12: Multi-core with coherency: coherent requests exchanged with cluster peers.
// R13: Bit 9 parity enable, reset 0; reads zero if parity absent.
// R14: Bit 8 restricts allocation to one cache way, reset 0.
// R15: Bit 7 enables disjoint L1/L2 caching, reset 0.
// R16: Bit 6 coherency; single core makes Inner Cacheable Shared cacheable.
// R17: Bits 3, 2, 1: zero-line writes, data prefetch, outer hints; reset 0.
// R18: Bit 0 broadcast enable, zero on single core; bits 5:4 read zero.
// R19: Software sets zero-line and hint enables only if memory slaves support them.
// R20: Software updates the auxiliary register by read-modify-write.
// R21: Access control governs coprocessors ten and eleven only.
// R22: Access control register is privileged-only and shared by both states.
// R23: Permission codes: 00 denied, 01 privileged, 10 reserved, 11 all.
// R24: Permission for an absent coprocessor always reads 00.
// R25: User-mode access to auxiliary or access control is undefined.
`timescale 1ns/100ps
`include "scar_cfg.svh"
module scar_regs #(
  parameter bit MULTI_CORE = 1'b1,
  parameter bit PARITY_IMPL = 1'b1,
  parameter bit COPROC_TEN_PERMISSION_PRESENT = 1'b1,
  parameter bit COPROC_ELEVEN_PERMISSION_PRESENT = 1'b1,
  parameter logic [31:0] MAIN_RESET = `SCAR_MAIN_RESET,
  parameter logic [31:0] MAIN_RO_MASK = `SCAR_MAIN_RO_MASK,
  parameter logic [31:0] MAIN_SEC_ONLY_MASK = `SCAR_MAIN_SEC_ONLY_MASK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [3:0] req_cp_num,
  input wire logic [2:0] req_opc1,
  input wire logic [3:0] req_crn,
  input wire logic [3:0] req_crm,
  input wire logic [2:0] req_opc2,
  input wire logic [31:0] req_wdata,
  input wire logic req_user,
  input wire logic req_nonsecure,
  input wire logic secure_config_lock_input,
  input wire logic nonsecure_coherency_permission,
  output logic resp_valid,
  output logic resp_undef,
  output logic [31:0] resp_rdata,
  input wire logic use_valid,
  input wire logic [3:0] use_cp_num,
  input wire logic use_user,
  output logic use_done,
  output logic use_denied,
  output logic [31:0] main_system_control_secure,
  output logic [31:0] main_system_control_nonsecure,
  output logic parity_check_enable,
  output logic single_way_alloc,
  output logic l1_l2_disjoint_caching,
  output logic coherency_participate,
  output logic zero_line_write_enable,
  output logic dside_prefetch_enable,
  output logic outer_prefetch_hint_enable,
  output logic maintenance_broadcast_enable,
  output logic ics_as_cacheable,
  output logic maint_bcast_send_en,
  output logic maint_bcast_recv_en,
  output logic coherent_req_en,
  output logic [1:0] coproc_ten_permission,
  output logic [1:0] coproc_eleven_permission
);
  import scar_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam logic [31:0] AUX_WMASK = `SCAR_AUX_BASE_WMASK |
    (32'(PARITY_IMPL) << `SCAR_AUX_PARITY) | (32'(MULTI_CORE) << `SCAR_AUX_MAINT_BC);
  localparam logic [31:0] AUX_NS_WMASK = 32'h0000_0001 << `SCAR_AUX_COHERENT;
  localparam logic [31:0] CPA_WMASK =
    ({30'h0000_0000, {2{COPROC_TEN_PERMISSION_PRESENT}}} << `SCAR_CPA_TEN_LSB) |
    ({30'h0000_0000, {2{COPROC_ELEVEN_PERMISSION_PRESENT}}} << `SCAR_CPA_ELEVEN_LSB);

  scar_state_t state;
  scar_sel_t sel;
  logic take;
  logic undef_c;
  logic [31:0] main_rd;
  logic [31:0] rd_c;
  logic main_s_we;
  logic main_ns_we;
  logic aux_we;
  logic cpa_we;
  logic [31:0] aux_mask;
  logic [31:0] aux;
  logic [31:0] cpa;
  logic [1:0] use_perm;

  scar_decode u_decode (
    .cp_num(req_cp_num),
    .opc1(req_opc1),
    .crn(req_crn),
    .crm(req_crm),
    .opc2(req_opc2),
    .sel(sel)
  );

  assign req_ready = (state == SCAR_S_IDLE);
  assign take = req_valid && req_ready;

  always_comb begin
    undef_c = 1'b0;
    if (sel == SCAR_SEL_NONE) begin
      undef_c = 1'b1;
    end else if (req_user) begin
      undef_c = 1'b1; // [R1] [R8] [R22] [R25]
    end else if (req_write && !req_nonsecure && secure_config_lock_input &&
                 (sel == SCAR_SEL_MAIN || sel == SCAR_SEL_AUX)) begin
      undef_c = 1'b1; // [R2]
    end
  end

  // Read-only bits never take part in a write; Secure-only bits only from Secure
  assign main_s_we = take && req_write && !undef_c && sel == SCAR_SEL_MAIN &&
                     !req_nonsecure; // [R5]
  assign main_ns_we = take && req_write && !undef_c && sel == SCAR_SEL_MAIN &&
                      req_nonsecure; // [R3]

  scar_field_reg #(.W(32), .RESET_VAL(MAIN_RESET)) u_main_s (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(main_s_we),
    .wr_mask(~MAIN_RO_MASK), // [R5]
    .wr_data(req_wdata),
    .q(main_system_control_secure)
  );

  scar_field_reg #(.W(32), .RESET_VAL(MAIN_RESET)) u_main_ns (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(main_ns_we),
    .wr_mask(~(MAIN_RO_MASK | MAIN_SEC_ONLY_MASK)), // [R3] [R5]
    .wr_data(req_wdata),
    .q(main_system_control_nonsecure)
  );

  // A Non-secure write without permission is dropped quietly, not faulted
  assign aux_we = take && req_write && !undef_c && sel == SCAR_SEL_AUX &&
                  (!req_nonsecure || nonsecure_coherency_permission); // [R9]
  assign aux_mask = req_nonsecure ? (AUX_NS_WMASK & AUX_WMASK) : AUX_WMASK; // [R8] [R9]

  scar_field_reg #(.W(32), .RESET_VAL(`SCAR_AUX_RESET)) u_aux (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(aux_we),
    .wr_mask(aux_mask), // [R13] [R18]
    .wr_data(req_wdata),
    .q(aux)
  );

  assign cpa_we = take && req_write && !undef_c && sel == SCAR_SEL_CPA;

  // Absent coprocessor fields have no writable bits, so they stay denied
  scar_field_reg #(.W(32), .RESET_VAL(`SCAR_CPA_RESET)) u_cpa (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(cpa_we),
    .wr_mask(CPA_WMASK), // [R24]
    .wr_data(req_wdata),
    .q(cpa)
  );

  assign main_rd = req_nonsecure ?
    ((main_system_control_nonsecure & ~MAIN_SEC_ONLY_MASK) |
     (main_system_control_secure & MAIN_SEC_ONLY_MASK)) :
    main_system_control_secure; // [R4]

  always_comb begin
    case (sel)
      SCAR_SEL_MAIN: rd_c = main_rd;
      SCAR_SEL_AUX: rd_c = aux;
      SCAR_SEL_CPA: rd_c = cpa;
      default: rd_c = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SCAR_S_IDLE;
    end else begin
      case (state)
        SCAR_S_IDLE: if (take) state <= SCAR_S_RESP;
        SCAR_S_RESP: state <= SCAR_S_IDLE;
        default: state <= SCAR_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_undef <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else begin
      resp_valid <= take;
      if (take) begin
        resp_undef <= undef_c;
        resp_rdata <= (req_write || undef_c) ? 32'h0000_0000 : rd_c;
      end
    end
  end

  assign parity_check_enable = aux[`SCAR_AUX_PARITY]; // [R13]
  assign single_way_alloc = aux[`SCAR_AUX_ONE_WAY]; // [R14]
  assign l1_l2_disjoint_caching = aux[`SCAR_AUX_DISJOINT]; // [R15]
  assign coherency_participate = aux[`SCAR_AUX_COHERENT]; // [R16]
  assign zero_line_write_enable = aux[`SCAR_AUX_ZERO_LINE]; // [R17]
  assign dside_prefetch_enable = aux[`SCAR_AUX_DSIDE_PF]; // [R17]
  assign outer_prefetch_hint_enable = aux[`SCAR_AUX_OUTER_PF]; // [R17]
  assign maintenance_broadcast_enable = aux[`SCAR_AUX_MAINT_BC]; // [R18]

  // Shareable cacheable memory is cached only while this core is coherent
  assign ics_as_cacheable = coherency_participate; // [R10] [R16]
  assign maint_bcast_send_en = MULTI_CORE && coherency_participate &&
                               maintenance_broadcast_enable; // [R11]
  assign maint_bcast_recv_en = maint_bcast_send_en; // [R11]
  assign coherent_req_en = MULTI_CORE && coherency_participate; // [R12]

  assign coproc_ten_permission = cpa[`SCAR_CPA_TEN_LSB +: 2];
  assign coproc_eleven_permission = cpa[`SCAR_CPA_ELEVEN_LSB +: 2];

  // Only coprocessors ten and eleven are checked; every other number passes
  always_comb begin
    case (use_cp_num)
      `SCAR_CP_TEN: use_perm = coproc_ten_permission; // [R21]
      `SCAR_CP_ELEVEN: use_perm = coproc_eleven_permission; // [R21]
      default: use_perm = `SCAR_PERM_FULL;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      use_done <= 1'b0;
      use_denied <= 1'b0;
    end else begin
      use_done <= use_valid;
      if (use_valid) begin
        // Reserved code 10 is treated as denied
        use_denied <= !(use_perm == `SCAR_PERM_FULL ||
                        (use_perm == `SCAR_PERM_PRIV && !use_user)); // [R23]
      end
    end
  end

  sequence s_take_user;
    take && req_user;
  endsequence

  sequence s_take_locked_write;
    take && req_write && !req_user && !req_nonsecure && secure_config_lock_input &&
      (sel == SCAR_SEL_MAIN || sel == SCAR_SEL_AUX);
  endsequence

  sequence s_undef_answer;
    resp_valid && resp_undef && !req_ready;
  endsequence

  AST_USER_UNDEF: assert property (s_take_user |=> s_undef_answer) // [R1]
    else $error("User-mode transfer not answered as undefined");

  AST_LOCK_UNDEF: assert property (s_take_locked_write |=> s_undef_answer ##1 req_ready) // [R2]
    else $error("Locked Secure write not answered as undefined");

  AST_UNDEF_NO_WRITE: assert property (take && undef_c |=> // [R1] [R2] [R25]
    $stable(aux) && $stable(cpa) && $stable(main_system_control_secure) &&
    $stable(main_system_control_nonsecure))
    else $error("Undefined transfer changed a register");

  AST_NS_KEEPS_SECURE: assert property (take && req_nonsecure |=> // [R3]
    (main_system_control_secure == $past(main_system_control_secure)))
    else $error("Non-secure access changed the Secure copy");

  AST_NS_SEC_BIT_HELD: assert property (take && req_nonsecure |=> // [R3]
    ((main_system_control_nonsecure & MAIN_SEC_ONLY_MASK) ==
    ($past(main_system_control_nonsecure) & MAIN_SEC_ONLY_MASK)))
    else $error("Non-secure write changed a Secure-only bit");

  AST_READ_SECURE_COPY: assert property (take && !req_write && !undef_c && // [R4]
    sel == SCAR_SEL_MAIN |=> ((resp_rdata & MAIN_SEC_ONLY_MASK) ==
    (main_system_control_secure & MAIN_SEC_ONLY_MASK)))
    else $error("Secure-only bits did not read the Secure copy");

  AST_RO_HELD: assert property (((main_system_control_secure & MAIN_RO_MASK) == // [R5]
    (MAIN_RESET & MAIN_RO_MASK)) && ((main_system_control_nonsecure & MAIN_RO_MASK) ==
    (MAIN_RESET & MAIN_RO_MASK)))
    else $error("Read-only main control bits changed");

  AST_AUX_SECURE_WRITE: assert property (take && req_write && !undef_c && // [R8]
    !req_nonsecure && sel == SCAR_SEL_AUX |=> (aux == ($past(req_wdata) & AUX_WMASK)))
    else $error("Secure write did not store every writable auxiliary bit");

  AST_AUX_NS_ONLY_COH: assert property (take && req_nonsecure && req_write |=> // [R9]
    ((aux & ~AUX_NS_WMASK) == ($past(aux) & ~AUX_NS_WMASK)))
    else $error("Non-secure write changed an auxiliary bit other than coherency");

  AST_AUX_NS_LOCKED: assert property (take && req_nonsecure && req_write && // [R9]
    !nonsecure_coherency_permission |=> $stable(aux))
    else $error("Non-secure write changed auxiliary without permission");

  AST_AUX_NS_COH_WRITE: assert property (take && req_nonsecure && req_write && // [R9]
    !undef_c && sel == SCAR_SEL_AUX && nonsecure_coherency_permission |=>
    (coherency_participate == $past(req_wdata[`SCAR_AUX_COHERENT])))
    else $error("Permitted Non-secure write did not set the coherency bit");

  AST_AUX_RAZ: assert property ((aux & ~AUX_WMASK) == 32'h0000_0000) // [R13] [R18]
    else $error("Reserved auxiliary bits are not zero");

  AST_COH_CACHE: assert property (!coherency_participate |-> // [R10] [R11] [R12]
    !ics_as_cacheable && !coherent_req_en && !maint_bcast_send_en)
    else $error("Coherent behaviour active without coherency participation");

  AST_USE_CHECK: assert property (use_valid && use_cp_num != `SCAR_CP_TEN && // [R21]
    use_cp_num != `SCAR_CP_ELEVEN |=> use_done && !use_denied)
    else $error("Access control affected an unrelated coprocessor");

  AST_USE_TEN_DENIED: assert property (use_valid && use_cp_num == `SCAR_CP_TEN && // [R23]
    coproc_ten_permission == `SCAR_PERM_DENIED |=> use_done && use_denied)
    else $error("Denied coprocessor ten use was not refused");

  AST_CPA_RAZ: assert property ((cpa & ~CPA_WMASK) == 32'h0000_0000) // [R21] [R24]
    else $error("Access control bits outside present fields are not zero");

  AST_ABSENT_DENIED: assert property (!COPROC_TEN_PERMISSION_PRESENT |-> // [R24]
    coproc_ten_permission == `SCAR_PERM_DENIED)
    else $error("Absent coprocessor ten shows a permission");

  AST_ABSENT_ELEVEN: assert property (!COPROC_ELEVEN_PERMISSION_PRESENT |-> // [R24]
    coproc_eleven_permission == `SCAR_PERM_DENIED)
    else $error("Absent coprocessor eleven shows a permission");
endmodule

// ---- test/scar_pipe_model.sv ----
/*
  Pipeline model that issues coprocessor register transfers to the bank.
  Assumes a free-running clk and that callers start a transfer at a falling edge.
*/
`timescale 1ns/100ps
`include "scar_cfg.svh"
module scar_pipe_model (
  input wire logic clk,
  output logic req_valid,
  input wire logic req_ready,
  output logic req_write,
  output logic [3:0] req_cp_num,
  output logic [2:0] req_opc1,
  output logic [3:0] req_crn,
  output logic [3:0] req_crm,
  output logic [2:0] req_opc2,
  output logic [31:0] req_wdata,
  output logic req_user,
  output logic req_nonsecure,
  input wire logic resp_valid,
  input wire logic resp_undef,
  input wire logic [31:0] resp_rdata
);
  int idle_cycles = 0;
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_cp_num = 4'h0;
    req_opc1 = 3'h0;
    req_crn = 4'h0;
    req_crm = 4'h0;
    req_opc2 = 3'h0;
    req_wdata = 32'h0000_0000;
    req_user = 1'b0;
    req_nonsecure = 1'b0;
  end
  // Software side writes the auxiliary register with whatever value the caller passes
  // and the bench sets zero-line and hint enables with no check of memory support
  task automatic xfer(input logic wr, input logic [3:0] cp, input logic [2:0] op2,
                      input logic [31:0] d, input logic usr, input logic ns,
                      output logic undef, output logic [31:0] rdata);
    int n;
    // One edge always passes, so back-to-back calls never redrive valid in one step
    repeat (idle_cycles + 1) @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_cp_num = cp;
    req_opc1 = `SCAR_OPC1_CTL;
    req_crn = `SCAR_CRN_CTL;
    req_crm = `SCAR_CRM_CTL;
    req_opc2 = op2;
    req_wdata = d;
    req_user = usr;
    req_nonsecure = ns;
    n = 0;
    while (req_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    undef = resp_valid === 1'b1 ? resp_undef : 1'bx;
    rdata = resp_valid === 1'b1 ? resp_rdata : 32'hxxxx_xxxx;
    // Data, opcode2 and coprocessor number lines must not keep showing the old value
    req_valid = 1'b0;
    req_wdata = ~d;
    req_opc2 = ~op2;
    req_cp_num = ~cp;
  endtask
endmodule

// ---- test/system_ctrl_aux_regs_test.sv ----
/*
  Self-checking bench for the system control register bank.
  Assumes the pipeline model drives transfers; the second coprocessor is absent.
*/
`timescale 1ns/100ps
`include "scar_cfg.svh"
module system_ctrl_aux_regs_test;
  logic clk = 1'b0, rst_n = 1'b0, lock = 1'b0, perm = 1'b0;
  logic req_valid, req_ready, req_write, req_user, req_nonsecure, resp_valid, resp_undef;
  logic [3:0] req_cp_num, req_crn, req_crm, use_cp_num = 4'h0;
  logic [2:0] req_opc1, req_opc2;
  logic [31:0] req_wdata, resp_rdata, msc_s, msc_ns, sec, rd;
  logic use_valid = 1'b0, use_user = 1'b0, use_done, use_denied, u;
  logic [7:0] aux_o;
  logic [3:0] der_o;
  logic [1:0] p10, p11;
  int err_total = 0, num_checks = 0;
  initial forever #2 clk = ~clk;
  scar_regs #(.COPROC_ELEVEN_PERMISSION_PRESENT(1'b0)) i_scar_regs (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_cp_num(req_cp_num), .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm),
    .req_opc2(req_opc2), .req_wdata(req_wdata), .req_user(req_user),
    .req_nonsecure(req_nonsecure), .secure_config_lock_input(lock),
    .nonsecure_coherency_permission(perm), .resp_valid(resp_valid),
    .resp_undef(resp_undef), .resp_rdata(resp_rdata), .use_valid(use_valid),
    .use_cp_num(use_cp_num), .use_user(use_user), .use_done(use_done),
    .use_denied(use_denied), .main_system_control_secure(msc_s),
    .main_system_control_nonsecure(msc_ns), .parity_check_enable(aux_o[7]),
    .single_way_alloc(aux_o[6]), .l1_l2_disjoint_caching(aux_o[5]),
    .coherency_participate(aux_o[4]), .zero_line_write_enable(aux_o[3]),
    .dside_prefetch_enable(aux_o[2]), .outer_prefetch_hint_enable(aux_o[1]),
    .maintenance_broadcast_enable(aux_o[0]), .ics_as_cacheable(der_o[3]),
    .maint_bcast_send_en(der_o[2]), .maint_bcast_recv_en(der_o[1]),
    .coherent_req_en(der_o[0]), .coproc_ten_permission(p10),
    .coproc_eleven_permission(p11));
  scar_pipe_model i_scar_pipe_model (.clk(clk), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_cp_num(req_cp_num),
    .req_opc1(req_opc1), .req_crn(req_crn), .req_crm(req_crm), .req_opc2(req_opc2),
    .req_wdata(req_wdata), .req_user(req_user), .req_nonsecure(req_nonsecure),
    .resp_valid(resp_valid), .resp_undef(resp_undef), .resp_rdata(resp_rdata));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic wr, input logic [3:0] cp, input logic [2:0] op2,
                     input logic [31:0] d, input logic usr, input logic ns, input logic eu);
    i_scar_pipe_model.xfer(wr, cp, op2, d, usr, ns, u, rd);
    chk("undef", 32'(u), 32'(eu));
    if (wr || eu) chk("null_rdata", rd, 32'h0000_0000);
  endtask
  task automatic rd_chk(input logic [2:0] op2, input logic ns, input logic [31:0] exp);
    acc(1'b0, `SCAR_CP_SYS, op2, 32'h0000_0000, 1'b0, ns, 1'b0);
    chk("rdata", rd, exp);
  endtask
  task automatic use_chk(input logic [3:0] cp, input logic usr, input logic den);
    use_cp_num = cp;
    use_user = usr;
    use_valid = 1'b1;
    @(negedge clk);
    use_valid = 1'b0;
    chk("use_done", 32'(use_done), 32'h0000_0001);
    chk("use_denied", 32'(use_denied), 32'(den));
    @(negedge clk);
    chk("use_done_pulse", 32'(use_done), 32'h0000_0000);
    chk("use_denied_held", 32'(use_denied), 32'(den));
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    logic [1:0] c;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd_chk(`SCAR_OPC2_MAIN, 1'b0, `SCAR_MAIN_RESET);
    rd_chk(`SCAR_OPC2_AUX, 1'b0, 32'h0000_0000);
    rd_chk(`SCAR_OPC2_CPA, 1'b0, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, `SCAR_CP_SYS, 3'(i), 32'h0000_0000, 1'b1, 1'b0, 1'b1);
      acc(1'b1, `SCAR_CP_SYS, 3'(i), 32'hFFFF_FFFF, 1'b1, 1'b1, 1'b1);
    end
    acc(1'b0, `SCAR_CP_SYS, 3'h3, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
    acc(1'b0, 4'hE, `SCAR_OPC2_CPA, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
    i_scar_pipe_model.idle_cycles = 2;
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_AUX, 32'hFFFF_FFFF, 1'b0, 1'b0, 1'b0);
    rd_chk(`SCAR_OPC2_AUX, 1'b0, 32'h0000_03CF);
    chk("aux_outs", 32'(aux_o), 32'h0000_00FF);
    chk("derived", 32'(der_o), 32'h0000_000F);
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_AUX, 32'h0000_0000, 1'b0, 1'b1, 1'b0);
    rd_chk(`SCAR_OPC2_AUX, 1'b1, 32'h0000_03CF);
    perm = 1'b1;
    rd_chk(`SCAR_OPC2_AUX, 1'b1, 32'h0000_03CF);
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_AUX, rd & 32'hFFFF_FFBF, 1'b0, 1'b1, 1'b0);
    rd_chk(`SCAR_OPC2_AUX, 1'b0, 32'h0000_038F);
    chk("derived", 32'(der_o), 32'h0000_0000);
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_AUX, 32'h0000_0040, 1'b0, 1'b1, 1'b0);
    rd_chk(`SCAR_OPC2_AUX, 1'b0, 32'h0000_03CF);
    i_scar_pipe_model.idle_cycles = 0;
    lock = 1'b1;
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_AUX, 32'h0000_0000, 1'b0, 1'b0, 1'b1);
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_MAIN, 32'hFFFF_FFFF, 1'b0, 1'b0, 1'b1);
    rd_chk(`SCAR_OPC2_AUX, 1'b0, 32'h0000_03CF);
    rd_chk(`SCAR_OPC2_MAIN, 1'b0, `SCAR_MAIN_RESET);
    lock = 1'b0;
    sec = (`SCAR_MAIN_RESET & `SCAR_MAIN_RO_MASK) | ~`SCAR_MAIN_RO_MASK;
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_MAIN, 32'hFFFF_FFFF, 1'b0, 1'b0, 1'b0);
    rd_chk(`SCAR_OPC2_MAIN, 1'b0, sec);
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_MAIN, 32'h0000_0000, 1'b0, 1'b1, 1'b0);
    chk("main_secure", msc_s, sec);
    rd_chk(`SCAR_OPC2_MAIN, 1'b1, (`SCAR_MAIN_RESET & `SCAR_MAIN_RO_MASK &
      ~`SCAR_MAIN_SEC_ONLY_MASK) | (sec & `SCAR_MAIN_SEC_ONLY_MASK));
    chk("main_nonsecure", msc_ns, `SCAR_MAIN_RESET & (`SCAR_MAIN_RO_MASK |
      `SCAR_MAIN_SEC_ONLY_MASK));
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_MAIN, 32'hFFFF_FFFF, 1'b0, 1'b1, 1'b0);
    chk("main_nonsecure", msc_ns, (`SCAR_MAIN_RESET & (`SCAR_MAIN_RO_MASK |
      `SCAR_MAIN_SEC_ONLY_MASK)) | ~(`SCAR_MAIN_RO_MASK | `SCAR_MAIN_SEC_ONLY_MASK));
    chk("main_secure", msc_s, sec);
    rd_chk(`SCAR_OPC2_MAIN, 1'b1, sec);
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_CPA, {8'h00, c, c, 20'h0_0000}, 1'b0, 1'b0,
        1'b0);
      rd_chk(`SCAR_OPC2_CPA, 1'b1, {8'h00, 2'b00, c, 20'h0_0000});
      chk("perm", {28'h000_0000, p11, p10}, {28'h000_0000, 2'b00, c});
      use_chk(4'hA, 1'b0, c == 2'b00 || c == 2'b10);
      use_chk(4'hA, 1'b1, c != 2'b11);
      use_chk(4'hB, 1'b0, 1'b1);
      use_chk(4'hF, 1'b1, 1'b0);
    end
    acc(1'b1, `SCAR_CP_SYS, `SCAR_OPC2_CPA, 32'h0000_0000, 1'b1, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
